// File: rtl/cluster_ctrl_pkg.sv
// Purpose: Shared constants for the cluster control-signal generator
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Offsets are byte addresses, one aligned word each
package cluster_ctrl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W         = 5;
	localparam logic [4:0]  CTRL_OFFSET    = 5'h00;
	localparam logic [4:0]  CLK_SEL_OFFSET = 5'h04;
	localparam logic [4:0]  CLR_SEL_OFFSET = 5'h08;
	localparam logic [4:0]  STATUS_OFFSET  = 5'h0c;
	localparam logic [4:0]  STATE_OFFSET   = 5'h10;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int          CTRL_FALL_ONE_BIT = 0;
	localparam int          CTRL_FALL_TWO_BIT = 1;
	localparam int          CTRL_PRESET_BIT   = 2;
	localparam logic [2:0]  CTRL_RESET        = 3'h0;
	localparam int          STATUS_COUNT_LSB  = 0;
	localparam int          STATUS_TICK1_BIT  = 8;
	localparam int          STATUS_TICK2_BIT  = 9;
	localparam int          CTRL_SET_SIZE     = 10;
	localparam int          COUNT_W           = 4;

	// Count of asserted shared controls
	function automatic logic [COUNT_W-1:0] count_ones(
		input logic [CTRL_SET_SIZE-1:0] v);
		logic [COUNT_W-1:0] n;
		n = 4'h0;
		for (int i = 0; i < CTRL_SET_SIZE; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

endpackage

// File: rtl/cluster_control_signal_gen.sv
// Purpose: Shared control-signal generator for one logic cluster
// Assumes: Clock sources are pins; other controls come from clk logic
// Notes:   Cluster clocks are one-cycle enable pulses, never gated clocks
module cluster_control_signal_gen
	import cluster_ctrl_pkg::*;
#(
	parameter int CELLS = 10
) (
	input  wire logic              clk,             // 50 MHz clock
	input  wire logic              rst_n,           // Async reset, low
	input  wire logic [ADDR_W-1:0] avs_address,     // Byte address
	input  wire logic              avs_read,        // Read request
	input  wire logic              avs_write,       // Write request
	input  wire logic [31:0]       avs_writedata,   // Write data
	output logic      [31:0]       avs_readdata,    // Read data
	output logic                   avs_waitrequest, // Stall
	input  wire logic              clk_src_one,     // Clock source pin one
	input  wire logic              clk_src_two,     // Clock source pin two
	input  wire logic              clk_ena_one,     // Enable for clock one
	input  wire logic              clk_ena_two,     // Enable for clock two
	input  wire logic              aclr_one,        // Async clear one
	input  wire logic              aclr_two,        // Async clear two
	input  wire logic              aload,           // Async load/preset
	input  wire logic              aload_data,      // Async load data
	input  wire logic              sclr,            // Sync clear
	input  wire logic              sload,           // Sync load
	input  wire logic              addnsub_in,      // Add/subtract select
	input  wire logic [CELLS-1:0]  cell_data,       // Normal cell data
	input  wire logic [CELLS-1:0]  sload_data,      // Sync load data
	output logic                   cluster_tick_one, // Cluster clock one
	output logic                   cluster_tick_two, // Cluster clock two
	output logic                   addnsub_out,     // Shared add/sub
	output logic      [CELLS-1:0]  cell_q           // Cell register outputs
);

	// ****************************************
	// Register bus
	// ****************************************
	logic [2:0]       ctrl_q;
	logic [CELLS-1:0] clk_sel_q;
	logic [CELLS-1:0] clr_sel_q;
	logic             ack_q;
	logic [31:0]      rdata_q;
	logic [31:0]      rdata_d;
	logic [COUNT_W-1:0] active_count;
	logic             tick_seen1_q;
	logic             tick_seen2_q;

	// Request decode; one wait cycle on every access
	wire bus_req  = avs_read | avs_write;
	wire wr_take  = avs_write & ack_q;
	wire rd_first = avs_read & ~ack_q;
	wire hit_ctrl = (avs_address == CTRL_OFFSET);
	wire hit_csel = (avs_address == CLK_SEL_OFFSET);
	wire hit_rsel = (avs_address == CLR_SEL_OFFSET);
	wire hit_stat = (avs_address == STATUS_OFFSET);
	wire hit_cell = (avs_address == STATE_OFFSET);
	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0;
		if (hit_ctrl) begin
			rdata_d[2:0] = ctrl_q;
		end else if (hit_csel) begin
			rdata_d[CELLS-1:0] = clk_sel_q;
		end else if (hit_rsel) begin
			rdata_d[CELLS-1:0] = clr_sel_q;
		end else if (hit_stat) begin
			rdata_d[STATUS_COUNT_LSB +: COUNT_W] = active_count;
			rdata_d[STATUS_TICK1_BIT] = tick_seen1_q;
			rdata_d[STATUS_TICK2_BIT] = tick_seen2_q;
		end else if (hit_cell) begin
			rdata_d[CELLS-1:0] = cell_q;
		end
	end

	// Acknowledge and read data capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (rd_first) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// Configuration writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= CTRL_RESET;
			clk_sel_q <= '0;
			clr_sel_q <= '0;
		end else if (wr_take) begin
			if (hit_ctrl) ctrl_q <= avs_writedata[2:0];
			if (hit_csel) clk_sel_q <= avs_writedata[CELLS-1:0];
			if (hit_rsel) clr_sel_q <= avs_writedata[CELLS-1:0];
		end
	end

	// ****************************************
	// Cluster clock generation
	// ****************************************
	logic [2:0] sync_one_q;
	logic [2:0] sync_two_q;

	// Source pins pass two flops, third stage for edge detect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_one_q <= 3'h0;
			sync_two_q <= 3'h0;
		end else begin
			sync_one_q <= {sync_one_q[1:0], clk_src_one};
			sync_two_q <= {sync_two_q[1:0], clk_src_two};
		end
	end

	// Edge polarity per clock, each gated by its own enable
	wire rise_one = sync_one_q[1] & ~sync_one_q[2];
	wire fall_one = ~sync_one_q[1] & sync_one_q[2];
	wire rise_two = sync_two_q[1] & ~sync_two_q[2];
	wire fall_two = ~sync_two_q[1] & sync_two_q[2];
	wire edge_one = ctrl_q[CTRL_FALL_ONE_BIT] ? fall_one : rise_one;
	wire edge_two = ctrl_q[CTRL_FALL_TWO_BIT] ? fall_two : rise_two;
	assign cluster_tick_one = edge_one & clk_ena_one;
	assign cluster_tick_two = edge_two & clk_ena_two;
	assign addnsub_out      = addnsub_in;

	// Sticky tick history, cleared on status read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_seen1_q <= 1'b0;
			tick_seen2_q <= 1'b0;
		end else begin
			tick_seen1_q <= cluster_tick_one |
				(tick_seen1_q & ~(rd_first & hit_stat));
			tick_seen2_q <= cluster_tick_two |
				(tick_seen2_q & ~(rd_first & hit_stat));
		end
	end

	// Number of shared controls asserted now, at most ten
	assign active_count = count_ones({sync_one_q[1], sync_two_q[1],
		clk_ena_one, clk_ena_two, aclr_one, aclr_two, sclr, aload,
		sload, addnsub_in});

	// ****************************************
	// Logic cell registers
	// ****************************************
	logic [CELLS-1:0] cell_q_q;
	logic [CELLS-1:0] cell_q_d;
	logic [CELLS-1:0] cell_clr;
	logic [CELLS-1:0] cell_tick;

	// Preset mode forces the load data high
	wire aload_val = ctrl_q[CTRL_PRESET_BIT] | aload_data;

	// Per-cell clock pair and clear choice from the one shared set
	always_comb begin
		for (int i = 0; i < CELLS; i++) begin
			cell_tick[i] = clk_sel_q[i] ? cluster_tick_two
				: cluster_tick_one;
			cell_clr[i] = clr_sel_q[i] ? aclr_two : aclr_one;
		end
	end

	// Next state: clear, then async load, then clocked actions
	always_comb begin
		for (int i = 0; i < CELLS; i++) begin
			if (cell_clr[i]) begin
				cell_q_d[i] = 1'b0;
			end else if (aload) begin
				cell_q_d[i] = aload_val;
			end else if (!cell_tick[i]) begin
				cell_q_d[i] = cell_q_q[i];
			end else if (sclr) begin
				cell_q_d[i] = 1'b0;
			end else if (sload) begin
				cell_q_d[i] = sload_data[i];
			end else begin
				cell_q_d[i] = cell_data[i];
			end
		end
	end

	// Cell storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cell_q_q <= '0;
		end else begin
			cell_q_q <= cell_q_d;
		end
	end

	// Async controls show at the outputs without waiting for a clock
	always_comb begin
		for (int i = 0; i < CELLS; i++) begin
			if (cell_clr[i]) begin
				cell_q[i] = 1'b0;
			end else if (aload) begin
				cell_q[i] = aload_val;
			end else begin
				cell_q[i] = cell_q_q[i];
			end
		end
	end

endmodule // cluster_control_signal_gen

// File: sim/cluster_pin_src.sv
// Purpose: Far-side clock source pins feeding the cluster
// Assumes: Bench holds each level for at least two clk cycles
// Notes:   Both pins move together so both cluster clocks fire
module cluster_pin_src (
	input  wire logic clk,         // Bench clock
	input  wire logic lvl,         // Requested pin level
	output logic      clk_src_one, // Pin one
	output logic      clk_src_two  // Pin two
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins change only just after a clock edge
	always_ff @(posedge clk) begin
		clk_src_one <= lvl;
		clk_src_two <= lvl;
	end
endmodule // cluster_pin_src

// File: sim/cluster_control_signal_gen_chk.sv
// Purpose: Port-level checks of the cluster control generator
// Assumes: Pin levels last at least two clk cycles
// Notes:   Bound to the top module
module cluster_gen_chk #(
	parameter int CELLS = 10
) (
	input wire logic             clk,              // Clock
	input wire logic             rst_n,            // Reset, low
	input wire logic             clk_ena_one,      // Enable one
	input wire logic             clk_ena_two,      // Enable two
	input wire logic             aclr_one,         // Clear one
	input wire logic             aclr_two,         // Clear two
	input wire logic             aload,            // Async load
	input wire logic             aload_data,       // Load data
	input wire logic             sclr,             // Sync clear
	input wire logic             addnsub_in,       // Add/sub in
	input wire logic             addnsub_out,      // Add/sub out
	input wire logic             cluster_tick_one, // Tick one
	input wire logic             cluster_tick_two, // Tick two
	input wire logic [CELLS-1:0] cell_q            // Cells
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// No tick and no async control in this cycle
	wire na = !aclr_one && !aclr_two && !aload;
	wire quiet = na && !cluster_tick_one && !cluster_tick_two;
	// Pairing, pulse shape and async priority of the shared set
	chk_tick_one_ena: assert property (
		cluster_tick_one |-> clk_ena_one)
		else $error("tick one without enable");
	chk_tick_two_ena: assert property (
		cluster_tick_two |-> clk_ena_two)
		else $error("tick two without enable");
	chk_tick_pulse: assert property (
		cluster_tick_one |=> !cluster_tick_one)
		else $error("tick one longer than a cycle");
	chk_clear_wins: assert property (
		aclr_one && aclr_two |-> cell_q == '0)
		else $error("cells not cleared");
	chk_preset_ones: assert property (
		aload && aload_data && !aclr_one && !aclr_two |-> cell_q == '1)
		else $error("cells not preset");
	chk_addsub_pass: assert property (
		addnsub_out == addnsub_in)
		else $error("add/sub not passed");
	chk_hold_quiet: assert property (
		quiet ##1 quiet |-> $stable(cell_q))
		else $error("cells changed without cause");
	chk_sclr_edge: assert property (
		na && cluster_tick_one && cluster_tick_two && sclr ##1 na
		|-> cell_q == '0)
		else $error("sync clear missed");
	// Main scenarios reached
	cover property (cluster_tick_one && sclr);
	cover property (aload && aclr_one);
	cover property (cluster_tick_two);
	cover property (aload && !aload_data && cell_q == '1);
endmodule // cluster_gen_chk
bind cluster_control_signal_gen cluster_gen_chk #(.CELLS(CELLS)) i_chk (
	.clk              (clk),
	.rst_n            (rst_n),
	.clk_ena_one      (clk_ena_one),
	.clk_ena_two      (clk_ena_two),
	.aclr_one         (aclr_one),
	.aclr_two         (aclr_two),
	.aload            (aload),
	.aload_data       (aload_data),
	.sclr             (sclr),
	.addnsub_in       (addnsub_in),
	.addnsub_out      (addnsub_out),
	.cluster_tick_one (cluster_tick_one),
	.cluster_tick_two (cluster_tick_two),
	.cell_q           (cell_q)
);

// File: sim/cluster_control_signal_gen_tb.sv
// Purpose: Self-checking bench of the cluster control generator
// Assumes: Slave answers within twenty cycles
// Notes:   Pin levels held six cycles so every tick lands
module cluster_control_signal_gen_tb import cluster_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, lvl = 0;
	logic clk_ena_one = 1, clk_ena_two = 1, aclr_one = 0, aclr_two = 0;
	logic aload = 0, aload_data = 0, sclr = 0, sload = 0, addnsub_in = 0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
	logic [9:0] cell_data = 10'h000, sload_data = 10'h000, cell_q;
	logic avs_waitrequest, clk_src_one, clk_src_two;
	logic cluster_tick_one, cluster_tick_two, addnsub_out;
	int n_errors = 0, n_tests = 0;
	int n_tick1 = 0, n_tick2 = 0;
	always #10 clk = ~clk;
	// Count cluster clock pulses seen by the cells
	always @(posedge clk) begin
		if (cluster_tick_one === 1'b1) n_tick1++;
		if (cluster_tick_two === 1'b1) n_tick2++;
	end
	cluster_control_signal_gen #(.CELLS(10)) i_dut (.clk, .rst_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .clk_src_one, .clk_src_two, .clk_ena_one,
		.clk_ena_two, .aclr_one, .aclr_two, .aload, .aload_data, .sclr,
		.sload, .addnsub_in, .cell_data, .sload_data, .cluster_tick_one,
		.cluster_tick_two, .addnsub_out, .cell_q);
	cluster_pin_src i_src (.clk, .lvl, .clk_src_one, .clk_src_two);
	task automatic print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			n_errors++;
			print_verdict();
		end else begin
			r = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task automatic pin(input logic v);
		@(posedge clk);
		lvl <= v;
		repeat (6) @(posedge clk);
	endtask
	task automatic cq(input logic [9:0] e);
		chk({22'h0, cell_q}, {22'h0, e});
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, STATE_OFFSET, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, addnsub_out}, 32'h0);
		cell_data <= 10'h2a5;
		pin(1'b1);
		pin(1'b0);
		cq(10'h2a5);
		clk_ena_one <= 1'b0;
		clk_ena_two <= 1'b0;
		cell_data <= 10'h15a;
		pin(1'b1);
		pin(1'b0);
		cq(10'h2a5);
		clk_ena_one <= 1'b1;
		clk_ena_two <= 1'b1;
		bus(1'b1, CTRL_OFFSET, 32'h3);
		pin(1'b1);
		cq(10'h2a5);
		pin(1'b0);
		cq(10'h15a);
		bus(1'b1, CTRL_OFFSET, 32'h0);
		sload <= 1'b1;
		sload_data <= 10'h0f0;
		pin(1'b1);
		cq(10'h0f0);
		sclr <= 1'b1;
		pin(1'b0);
		pin(1'b1);
		cq(10'h000);
		sclr <= 1'b0;
		sload <= 1'b0;
		bus(1'b1, CLK_SEL_OFFSET, 32'h3e0);
		cell_data <= 10'h3ff;
		clk_ena_two <= 1'b0;
		pin(1'b0);
		pin(1'b1);
		cq(10'h01f);
		clk_ena_two <= 1'b1;
		aclr_one <= 1'b1;
		@(posedge clk);
		cq(10'h000);
		aclr_one <= 1'b0;
		aload <= 1'b1;
		aload_data <= 1'b1;
		@(posedge clk);
		cq(10'h3ff);
		// Load of a zero, then preset mode forcing ones
		aload_data <= 1'b0;
		@(posedge clk);
		cq(10'h000);
		bus(1'b1, CTRL_OFFSET, 32'h4);
		@(posedge clk);
		cq(10'h3ff);
		aload <= 1'b0;
		@(posedge clk);
		cq(10'h3ff);
		bus(1'b1, CTRL_OFFSET, 32'h0);
		// Cells five to nine follow the second clear
		bus(1'b1, CLR_SEL_OFFSET, 32'h3e0);
		aclr_two <= 1'b1;
		@(posedge clk);
		cq(10'h01f);
		aload <= 1'b1;
		aclr_one <= 1'b1;
		sclr <= 1'b1;
		sload <= 1'b1;
		addnsub_in <= 1'b1;
		pin(1'b1);
		cq(10'h000);
		chk({31'h0, addnsub_out}, 32'h1);
		bus(1'b0, STATUS_OFFSET, 32'h0);
		chk(r, 32'h30a);
		bus(1'b0, STATUS_OFFSET, 32'h0);
		chk(r, 32'h00a);
		chk(n_tick1, 32'h5);
		chk(n_tick2, 32'h4);
		bus(1'b1, 5'h14, 32'hffff);
		bus(1'b0, 5'h14, 32'h0);
		chk(r, 32'h0);
		print_verdict();
	end
endmodule // cluster_control_signal_gen_tb
